// >>> hw/uimg_pkg.sv
// Shared constants for the UART interrupt mask gate.
package uimg_pkg;
  // ==========================================================================
  // Bus and source geometry.
  // ==========================================================================
  localparam int unsigned ADDR_W = 12;  // Byte address width seen by the block.
  localparam int unsigned DATA_W = 32;  // APB data width.
  localparam int unsigned SRC_N  = 7;   // Interrupt sources, bits 10 down to 4.
  localparam int unsigned SRC_LO = 4;   // Lowest source bit in every register.
  localparam int unsigned SRC_HI = 10;  // Highest source bit in every register.

  // ==========================================================================
  // Register offsets (byte addresses).
  // ==========================================================================
  localparam logic [11:0] OFF_ENABLE   = 12'h038;  // Per-source enable mask.
  localparam logic [11:0] OFF_RAW      = 12'h03C;  // Raw source state.
  localparam logic [11:0] OFF_MASKED   = 12'h040;  // Raw state gated by enables.
  localparam logic [11:0] OFF_EVT_STAT = 12'h044;  // Sticky event flags, read clears.
  localparam logic [11:0] OFF_EVT_MASK = 12'h048;  // Event flags allowed onto irq.

  // ==========================================================================
  // Field positions inside every source-layout register.
  // ==========================================================================
  localparam int unsigned BIT_RX      = 4;   // Receive.
  localparam int unsigned BIT_TX      = 5;   // Transmit.
  localparam int unsigned BIT_RX_TO   = 6;   // Receive time-out.
  localparam int unsigned BIT_FRAMING = 7;   // Framing error.
  localparam int unsigned BIT_PARITY  = 8;   // Parity error.
  localparam int unsigned BIT_BREAK   = 9;   // Break error.
  localparam int unsigned BIT_OVERRUN = 10;  // Overrun error.

  // ==========================================================================
  // Reset and reserved values.
  // ==========================================================================
  localparam logic [6:0] ENABLE_RST   = 7'h00;  // All sources blocked after reset.
  localparam logic [6:0] EVT_MASK_RST = 7'h00;  // No event reaches irq after reset.
  localparam logic [3:0] RSVD_ZERO    = 4'h0;   // Low reserved bits of most registers.
  localparam logic [3:0] RAW_RSVD     = 4'hF;   // Low reserved bits of the raw register.
endpackage

// >>> hw/uimg_enable_reg.sv
// Per-source enable mask register with a write port.
`timescale 1ns/100ps
`default_nettype none
module uimg_enable_reg
  import uimg_pkg::*;
(
  input  wire logic             pclk,      // Peripheral clock.
  input  wire logic             presetn,   // Asynchronous reset, active low.
  input  wire logic             wr_en,     // One-cycle write strobe.
  input  wire logic [SRC_N-1:0] wr_data,   // New enable bits, source order.
  output var  logic [SRC_N-1:0] enable_r   // Enable bits currently held.
);
  logic [SRC_N-1:0] enable_nxt;  // Next value of the enable bits.

  // Next value: a write replaces the whole field, otherwise hold.
  always_comb
  begin
    enable_nxt = enable_r;
    if (wr_en)
    begin
      enable_nxt = wr_data;
    end
  end

  // Register the enables; every bit clears on reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r <= ENABLE_RST;  // see R03 R08 R09
    end
    else
    begin
      enable_r <= enable_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> hw/uimg_event_status.sv
// Sticky event flags set on a rising raw source and cleared by a read.
`timescale 1ns/100ps
`default_nettype none
module uimg_event_status
  import uimg_pkg::*;
(
  input  wire logic             pclk,      // Peripheral clock.
  input  wire logic             presetn,   // Asynchronous reset, active low.
  input  wire logic [SRC_N-1:0] raw_irq,   // Raw source levels, same clock.
  input  wire logic [SRC_N-1:0] clr_bits,  // Flags to clear this cycle.
  output var  logic [SRC_N-1:0] sticky_r   // Sticky event flags.
);
  logic [SRC_N-1:0] prev_r;      // Raw levels one cycle ago.
  logic [SRC_N-1:0] sticky_nxt;  // Next sticky flags.
  logic [SRC_N-1:0] rise;        // One-cycle pulse on each raw rising edge.

  // Next value: a new event wins over a clear in the same cycle.
  always_comb
  begin
    rise       = raw_irq & ~prev_r;
    sticky_nxt = (sticky_r & ~clr_bits) | rise;
  end

  // Register flags and the previous raw levels.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r   <= '0;
      sticky_r <= '0;
    end
    else
    begin
      prev_r   <= raw_irq;
      sticky_r <= sticky_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> hw/uimg_top.sv
// APB top of the UART interrupt mask gate with masked outputs and irq.
//
// Overview of operation
// R01: Set enable passes raw interrupt onward.
// R02: Break enable is bit 9, read/write.
// R03: Parity enable is bit 8, resets 0.
// R04: Framing enable is bit 7, readable.
// R05: Receive time-out enable is bit 6.
// R06: Receive enable bit 4 forwards receive.
// R07: Bits 3 to 0 of the enable register read as zero.
// R08: Transmit enable is bit 5, resets 0.
// R09: Overrun enable is bit 10, resets 0.
// R10: Clear enable blocks the raw interrupt.
// R11: Raw status ignores the enable bits.
// R12: Masked status is raw and enable; read-only.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module uimg_top
  import uimg_pkg::*;
(
  input  wire logic              pclk,        // Peripheral clock, 10 MHz.
  input  wire logic              presetn,     // Asynchronous reset, active low.
  input  wire logic              psel,        // APB select.
  input  wire logic              penable,     // APB access phase.
  input  wire logic              pwrite,      // APB direction, high writes.
  input  wire logic [ADDR_W-1:0] paddr,       // APB byte address.
  input  wire logic [DATA_W-1:0] pwdata,      // APB write data.
  output logic      [DATA_W-1:0] prdata,      // APB read data.
  output logic                   pready,      // APB ready.
  output logic                   pslverr,     // APB error on unmapped address.
  input  wire logic [SRC_N-1:0]  raw_irq,     // Raw sources, bit 0 is receive.
  output logic      [SRC_N-1:0]  masked_irq,  // Gated sources to the controller.
  output logic                   irq          // Level interrupt from event flags.
);
  // ==========================================================================
  // Helper functions.
  // ==========================================================================

  // Place a source vector into the register layout over given low bits.
  function automatic logic [DATA_W-1:0] place_src(input logic [SRC_N-1:0] v,
                                                   input logic [3:0] low);
    place_src = {21'h000000, v, low};
  endfunction

  // True when the address selects the given register word.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // ==========================================================================
  // State.
  // ==========================================================================
  logic [SRC_N-1:0]  enable_q;      // Enable mask from the register module.
  logic [SRC_N-1:0]  sticky_q;      // Sticky event flags.
  logic [SRC_N-1:0]  evt_mask_r;    // Event mask onto irq.
  logic [SRC_N-1:0]  evt_mask_nxt;  // Next event mask.
  logic [DATA_W-1:0] prdata_r;      // Read data register.
  logic [DATA_W-1:0] prdata_nxt;    // Next read data.
  logic              pready_r;      // Ready register.
  logic              pready_nxt;    // Next ready.
  logic              pslverr_r;     // Error register.
  logic              pslverr_nxt;   // Next error.
  logic [SRC_N-1:0]  masked_r;      // Registered gated sources.
  logic [SRC_N-1:0]  masked_nxt;    // Next gated sources.
  logic              irq_r;         // Registered interrupt.
  logic              irq_nxt;       // Next interrupt.
  logic              setup;         // Setup cycle of a transfer.
  logic              access;        // Completing access cycle.
  logic              mapped;        // Address lands on a register.
  logic              wr_enable;     // Write strobe for the enable mask.
  logic [SRC_N-1:0]  clr_bits;      // Event flags to clear on a read.

  // ==========================================================================
  // APB decode.
  // ==========================================================================

  // Transfer phases and the address check.
  always_comb
  begin
    setup  = psel & ~penable;
    access = psel & penable & pready_r;
    mapped = hit(paddr, OFF_ENABLE) | hit(paddr, OFF_RAW) | hit(paddr, OFF_MASKED)
           | hit(paddr, OFF_EVT_STAT) | hit(paddr, OFF_EVT_MASK);
    // Writes to raw and masked status fall through with no effect. // see R12
    wr_enable = access & pwrite & hit(paddr, OFF_ENABLE);
    // A read clears only the flags it returned, so a later event survives.
    if (access & ~pwrite & hit(paddr, OFF_EVT_STAT))
    begin
      clr_bits = prdata_r[SRC_HI:SRC_LO];
    end
    else
    begin
      clr_bits = '0;
    end
  end

  // ==========================================================================
  // Sub-blocks.
  // ==========================================================================

  // Enable mask; write data is taken from bits 10 down to 4. // see R02
  uimg_enable_reg u_enable (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_enable),
    .wr_data  (pwdata[SRC_HI:SRC_LO]),
    .enable_r (enable_q)
  );

  // Sticky event flags fed by the raw sources.
  uimg_event_status u_events (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw_irq  (raw_irq),
    .clr_bits (clr_bits),
    .sticky_r (sticky_q)
  );

  // ==========================================================================
  // Next values for bus answer, event mask, gated outputs and irq.
  // ==========================================================================
  always_comb
  begin
    // Ready follows the setup cycle, so every access takes one wait-free cycle.
    pready_nxt   = setup;
    pslverr_nxt  = setup & ~mapped;
    prdata_nxt   = prdata_r;
    evt_mask_nxt = evt_mask_r;
    if (setup & ~pwrite)
    begin
      // Read data is sampled in the setup cycle and held through access.
      prdata_nxt = '0;
      if (hit(paddr, OFF_ENABLE))
      begin
        // Reserved bits 3:0 and 31:11 read zero. // see R07
        prdata_nxt = place_src(enable_q, RSVD_ZERO);  // see R04 R05
      end
      else if (hit(paddr, OFF_RAW))
      begin
        // Raw state, untouched by the enables. // see R11
        prdata_nxt = place_src(raw_irq, RAW_RSVD);
      end
      else if (hit(paddr, OFF_MASKED))
      begin
        prdata_nxt = place_src(raw_irq & enable_q, RSVD_ZERO);  // see R12
      end
      else if (hit(paddr, OFF_EVT_STAT))
      begin
        prdata_nxt = place_src(sticky_q, RSVD_ZERO);
      end
      else if (hit(paddr, OFF_EVT_MASK))
      begin
        prdata_nxt = place_src(evt_mask_r, RSVD_ZERO);
      end
    end
    else if (setup & pwrite)
    begin
      // A write answers with zero data.
      prdata_nxt = '0;
    end
    if (access & pwrite & hit(paddr, OFF_EVT_MASK))
    begin
      evt_mask_nxt = pwdata[SRC_HI:SRC_LO];
    end
    // A set enable passes the source, a clear one blocks it. // see R01
    masked_nxt = raw_irq & enable_q;  // see R10
    // Receive at bit 4 and transmit at bit 5 follow the same gate. // see R06 R08 R09
    irq_nxt = |(sticky_q & evt_mask_r);
  end

  // ==========================================================================
  // Registers.
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r   <= '0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      evt_mask_r <= EVT_MASK_RST;
      masked_r   <= '0;
      irq_r      <= 1'b0;
    end
    else
    begin
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      evt_mask_r <= evt_mask_nxt;
      masked_r   <= masked_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign masked_irq = masked_r;
  assign irq        = irq_r;

  // ==========================================================================
  // Assertions and cover points.
  // ==========================================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic seen_r;  // Low only in the first clock after reset release.

  // Mark the first cycle after reset so reset values can be checked.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_r <= 1'b0;
    end
    else
    begin
      seen_r <= 1'b1;
    end
  end

  logic rd_enable;  // Completing read of the enable mask.
  logic rd_raw;     // Completing read of the raw state.
  logic rd_masked;  // Completing read of the masked state.

  // Qualified read completions used by the checks below.
  assign rd_enable = access & ~pwrite & hit(paddr, OFF_ENABLE);
  assign rd_raw    = access & ~pwrite & hit(paddr, OFF_RAW);
  assign rd_masked = access & ~pwrite & hit(paddr, OFF_MASKED);

  a_pass_enabled: assert property ( // see R01
    (raw_irq & enable_q) != '0 |=> (masked_irq & $past(raw_irq & enable_q))
                                   == $past(raw_irq & enable_q))
    else $error("Enabled raw interrupt did not reach the output.");

  a_block_disabled: assert property ( // see R10
    ##1 1'b1 |-> (masked_irq & ~$past(enable_q)) == '0)
    else $error("Disabled raw interrupt reached the output.");

  a_enable_readback: assert property ( // see R02
    wr_enable ##1 (!wr_enable [*2]) ##0 rd_enable
      |-> prdata[SRC_HI:SRC_LO] == $past(pwdata[SRC_HI:SRC_LO], 3))
    else $error("Enable read did not return the written value.");

  a_enable_write: assert property ( // see R04
    wr_enable |=> enable_q == $past(pwdata[SRC_HI:SRC_LO]))
    else $error("Enable write did not take effect.");

  a_enable_reset: assert property ( // see R03
    !seen_r |-> enable_q == ENABLE_RST && masked_irq == '0)
    else $error("Enables were not clear after reset.");

  a_reserved_zero: assert property ( // see R07
    rd_enable |-> prdata[3:0] == RSVD_ZERO && prdata[31:11] == '0)
    else $error("Reserved enable bits did not read zero.");

  a_raw_unmasked: assert property ( // see R11
    rd_raw |-> prdata[SRC_HI:SRC_LO] == $past(raw_irq))
    else $error("Raw status did not show the raw sources.");

  a_masked_read: assert property ( // see R12
    rd_masked |-> prdata[SRC_HI:SRC_LO] == $past(raw_irq & enable_q))
    else $error("Masked status was not raw and enable.");

  a_status_write: assert property ( // see R12
    access && pwrite && (hit(paddr, OFF_RAW) || hit(paddr, OFF_MASKED))
      |=> $stable(enable_q) && $stable(evt_mask_r))
    else $error("Write to a status register changed state.");

  a_ready_timing: assert property (
    setup |=> pready ##1 !pready)
    else $error("Ready was not one cycle after setup.");

  a_irq_level: assert property (
    (sticky_q & evt_mask_r) != '0 |=> irq)
    else $error("Unmasked event flag did not raise irq.");

  c_enable_write: cover property (wr_enable);
  c_masked_pass: cover property ((raw_irq & enable_q) != '0 ##1 masked_irq != '0);
  c_irq_rise: cover property (!irq ##1 irq);
  c_event_clear: cover property (clr_bits != '0 ##2 !irq);
endmodule
`default_nettype wire

// >>> verif/uimg_intc_model.sv
// Behavioural interrupt controller that counts irq assertions from the block.
`timescale 1ns/100ps
`default_nettype none
module uimg_intc_model
  import uimg_pkg::*;
(
  input  wire logic             pclk,        // Peripheral clock.
  input  wire logic             presetn,     // Asynchronous reset, active low.
  input  wire logic [SRC_N-1:0] masked_irq,  // Gated sources, watched only.
  input  wire logic             irq,         // Level interrupt from the block.
  output logic      [7:0]       irq_cnt      // Rising edges of irq taken.
);
  logic irq_q;  // Irq level one edge ago.

  // ==========================================================================
  // Edge counter
  // ==========================================================================
  // A new interrupt is taken only when the level rises, as a real controller would.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q   <= 1'b0;
      irq_cnt <= 8'h00;
    end
    else
    begin
      irq_q <= irq;
      if (irq && !irq_q)
        irq_cnt <= irq_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> verif/uart_interrupt_mask_gate_bench.sv
// Self-checking bench for the UART interrupt mask gate.
`timescale 1ns/100ps
`default_nettype none
module uart_interrupt_mask_gate_bench
  import uimg_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;  // Clock, reset and APB controls.
  logic [11:0] paddr;                                 // APB byte address.
  logic [31:0] pwdata, prdata, v;                     // Bus data and a random word.
  logic        pready, pslverr, irq, irq_m;           // Answers; irq level last checked.
  logic [6:0]  raw_irq, masked_irq, en, evm, st, cur; // Ports and bench register copies.
  logic [7:0]  irq_cnt, n_irq;                        // Model count and expected count.
  logic [32:0] exp_q[$];                              // Expected {pslverr, prdata} queue.
  int          failures, n_tests, seed, b;            // Counters, seed, loop index.

  // ==========================================================================
  // Clock and instances
  // ==========================================================================
  // The clock runs at 10 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  uimg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_irq(raw_irq), .masked_irq(masked_irq), .irq(irq));
  uimg_intc_model intc (.pclk(pclk), .presetn(presetn), .masked_irq(masked_irq),
    .irq(irq), .irq_cnt(irq_cnt));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; psel stays high so transfers can run back to back.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    logic rdy;
    rdy = 1'b0;
    exp_q.push_back(exp);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 16 && rdy !== 1'b1; k++)
    begin
      @(posedge pclk);
      rdy = pready;
    end
    if (rdy !== 1'b1)
    begin
      failures++;
      summarize();
    end
    penable <= 1'b0;
  endtask

  // A register word with the source bits in place and reserved bits zero.
  function automatic logic [31:0] w(input logic [6:0] x);
    return {21'h0, x, 4'h0};
  endfunction

  // Releases the bus for n edges.
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // Checks irq and notes each expected rise for the controller model.
  task automatic chk_irq();
    logic e;
    e = |(st & evm);
    if (e && !irq_m)
      n_irq = n_irq + 8'h01;
    irq_m = e;
    chk(33'(irq), 33'(e));
  endtask

  // Drives new raw levels, records rising edges as events, checks the outputs.
  task automatic set_raw(input logic [6:0] x);
    raw_irq <= x;
    st = st | (x & ~cur);
    cur = x;
    idle(3);
    chk(33'(masked_irq), 33'(cur & en));
    chk_irq();
  endtask

  // Applies reset for two edges and clears the bench copies.
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    en = 7'h00;
    evm = 7'h00;
    st = 7'h00;
    irq_m = 1'b0;
    n_irq = 8'h00;
  endtask

  // ==========================================================================
  // Monitor
  // ==========================================================================
  // Takes the oldest expectation at every completed transfer.
  always @(negedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        failures++;
        $display("ERROR t=%0t got=%h exp=none", $time, prdata);
      end
      else
        chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {failures, n_tests, seed} = {32'd0, 32'd0, 32'd42484};
    {presetn, psel, penable, pwrite, paddr, pwdata, raw_irq} = '0;
    {cur, irq_m} = '0;
    do_reset();
    apb(0, OFF_ENABLE, 0, 33'h0);
    apb(0, OFF_EVT_MASK, 0, 33'h0);
    apb(0, OFF_RAW, 0, {1'b0, 21'h0, 7'h00, RAW_RSVD});
    apb(0, 12'h04C, 0, {1'b1, 32'h0});
    apb(1, 12'h000, 32'hFFFFFFFF, {1'b1, 32'h0});
    apb(0, OFF_ENABLE, 0, 33'h0);
    set_raw(7'h7F);
    for (b = 0; b < 7; b++)
    begin
      en = 7'(1 << b);
      apb(1, OFF_ENABLE, w(en), 33'h0);
      apb(0, OFF_ENABLE, 0, {1'b0, w(en)});
      set_raw(cur);
      apb(0, OFF_MASKED, 0, {1'b0, w(cur & en)});
    end
    apb(1, OFF_MASKED, 32'hFFFFFFFF, 33'h0);
    apb(1, OFF_RAW, 32'h0, 33'h0);
    apb(0, OFF_MASKED, 0, {1'b0, w(cur & en)});
    apb(0, OFF_RAW, 0, {1'b0, 21'h0, cur, RAW_RSVD});
    for (b = 0; b < 8; b++)
    begin
      v = $random(seed);
      en = v[10:4];
      apb(1, OFF_ENABLE, v, 33'h0);
      apb(0, OFF_ENABLE, 0, {1'b0, w(en)});
      v = $random(seed);
      evm = v[10:4];
      apb(1, OFF_EVT_MASK, w(evm), 33'h0);
      apb(0, OFF_EVT_MASK, 0, {1'b0, w(evm)});
      idle(2);
      chk_irq();
      set_raw(v[26:20]);
      apb(0, OFF_RAW, 0, {1'b0, 21'h0, cur, RAW_RSVD});
      apb(0, OFF_MASKED, 0, {1'b0, w(cur & en)});
      apb(0, OFF_EVT_STAT, 0, {1'b0, w(st)});
      st = 7'h00;
      idle(2);
      chk_irq();
    end
    // Interrupt raised, masked, unmasked and cleared by a status read.
    evm = 7'h02;
    apb(1, OFF_EVT_MASK, w(evm), 33'h0);
    set_raw(cur & 7'h7D);
    set_raw(cur | 7'h02);
    evm = 7'h00;
    apb(1, OFF_EVT_MASK, w(evm), 33'h0);
    idle(2);
    chk_irq();
    evm = 7'h02;
    apb(1, OFF_EVT_MASK, w(evm), 33'h0);
    idle(2);
    chk_irq();
    apb(0, OFF_EVT_STAT, 0, {1'b0, w(st)});
    st = 7'h00;
    idle(2);
    chk_irq();
    chk(33'(irq_cnt), 33'(n_irq));
    // A second reset in mid-run brings every enable back to zero.
    set_raw(7'h00);
    do_reset();
    apb(0, OFF_ENABLE, 0, 33'h0);
    set_raw(7'h7F);
    chk(33'(irq_cnt), 33'(n_irq));
    summarize();
  end
endmodule
`default_nettype wire
